// >>> dbs_ctrl_model.sv
`timescale 1ns/100ps
module dbs_ctrl_model
   import dbs_pkg::*;
(
   input  wire logic clk,
   output dbs_clk_pins_t clk_pins
);
   // ====
   // controller pin clocks
   // ====
   logic [2:0] ph_r;
   initial ph_r = 3'h0;
   always @(negedge clk) ph_r <= ph_r + 3'h1;
   // output pair leads by a quarter period, so launch edges meet input edges only in single_clock_mode
   assign clk_pins.in_k    = ph_r[2];
   assign clk_pins.in_k_n  = ~ph_r[2];
   assign clk_pins.out_c   = ph_r[2] ^ ph_r[1];
   assign clk_pins.out_c_n = ~(ph_r[2] ^ ph_r[1]);
endmodule

// >>> dbs_fifo.sv
`timescale 1ns/100ps
module dbs_fifo
   import dbs_pkg::*;
#(
   parameter int W     = DBS_LANE_W * DBS_LANES,
   parameter int DEPTH = DBS_FIFO_DEPTH
)
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0]   cnt;
   } dbs_fifo_state_t;

   dbs_fifo_state_t st_r;
   dbs_fifo_state_t st_nxt;
   logic [W-1:0]    buf_mem [DEPTH];
   logic            push;
   logic            pop;

   // =========================================================
   // handshake
   // =========================================================
   assign in_ready  = (st_r.cnt != (PW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = buf_mem[st_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // =========================================================
   // pointers
   // =========================================================
   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.wp = (st_r.wp == PW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rp = (st_r.rp == PW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
      end
      if (push && !pop)
      begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // storage holds no control state, so it is left out of reset
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         buf_mem[st_r.wp] <= in_data;
      end
   end

endmodule

// >>> dbs_pkg.sv
package dbs_pkg;

   // =========================================================
   // array geometry
   // =========================================================
   localparam int DBS_LANE_W    = 9;
   localparam int DBS_LANES     = 4;
   localparam int DBS_ADDR_W    = 20;
   localparam int DBS_BURST_LEN = 2;
   localparam int DBS_BANKS     = 2;

   // =========================================================
   // read path buffering
   // =========================================================
   localparam int DBS_FIFO_DEPTH = 4;

   // =========================================================
   // reset values
   // =========================================================
   localparam logic DBS_OE_N_RST  = 1'b1;
   localparam logic DBS_BCNT_RST  = 1'b0;

   // =========================================================
   // types
   // =========================================================
   typedef enum logic [2:0] {
      DBS_IDLE,
      DBS_WR_LO,
      DBS_WR_HI,
      DBS_RD_LO,
      DBS_RD_HI
   } dbs_phase_t;

   // input and output clock pairs, all sampled as plain levels on clk
   typedef struct packed {
      logic in_k;
      logic in_k_n;
      logic out_c;
      logic out_c_n;
   } dbs_clk_pins_t;

endpackage

// >>> dbs_properties.sv
`timescale 1ns/100ps
module dbs_properties
   import dbs_pkg::*;
#(
   parameter int LANES  = DBS_LANES,
   parameter int ADDR_W = DBS_ADDR_W
)
(
   input wire logic                        clk,
   input wire logic                        rst_b,
   input wire dbs_clk_pins_t               clk_pins,
   input wire logic                        single_clock_mode,
   input wire logic                        cycle_define_n,
   input wire logic                        read_not_write,
   input wire logic [ADDR_W-2:0]           addr_hi,
   input wire logic                        burst_start_bit,
   input wire logic [LANES-1:0]            byte_lane_en_n,
   input wire logic [LANES*DBS_LANE_W-1:0] dq_in,
   input wire logic [LANES*DBS_LANE_W-1:0] dq_out,
   input wire logic                        dq_oe_n,
   input wire logic [1:0]                  echo_timing_pair
);
   // ====
   // helper state
   // ====
   dbs_clk_pins_t prev_r;
   logic [7:0]    age_r;
   logic [1:0]    sel;
   logic          kr;
   logic          lr;
   logic          rd;
   logic          wr;
   always_comb
   begin
      sel = single_clock_mode ? {clk_pins.in_k_n, clk_pins.in_k}
                              : {clk_pins.out_c_n, clk_pins.out_c};
      kr  = clk_pins.in_k & ~prev_r.in_k;
      lr  = |(sel & ~(single_clock_mode ? {prev_r.in_k_n, prev_r.in_k}
                                       : {prev_r.out_c_n, prev_r.out_c}));
      rd  = kr & ~cycle_define_n & read_not_write;
      wr  = kr & ~cycle_define_n & ~read_not_write;
   end
   // age saturates so a long idle never wraps back into the drive window
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prev_r <= '0;
         age_r  <= 8'hff;
      end
      else
      begin
         prev_r <= clk_pins;
         age_r  <= rd ? 8'h00 : age_r + {7'h0, age_r != 8'hff};
      end
   end
   // ====
   // properties
   // ====
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   echo_follow_a: assert property ($past(rst_b) |-> echo_timing_pair == $past(sel))
      else $error("echo pair does not follow launch clocks");
   oe_launch_a: assert property ($changed(dq_oe_n) |-> $past(lr) || $past(lr, 2))
      else $error("output enable moved off a launch edge");
   out_stable_a: assert property (!$past(lr) && !$past(lr, 2) |-> $stable(dq_out))
      else $error("read data moved off a launch edge");
   float_idle_a: assert property (age_r > 8'd30 |-> dq_oe_n)
      else $error("data driven long after last read");
   read_answer_a: assert property (rd |-> ##[1:12] !dq_oe_n)
      else $error("read command not answered");
   drive_cause_a: assert property ($fell(dq_oe_n) |-> age_r < 8'd12)
      else $error("data driven without a read command");
   reset_float_a: assert property ($rose(rst_b) |-> dq_oe_n && dq_out == '0)
      else $error("data bus not floating in reset");
   echo_reset_a: assert property ($rose(rst_b) |-> echo_timing_pair == 2'h0)
      else $error("echo pair not cleared in reset");
   cover property (rd && single_clock_mode);
   cover property (wr);
   cover property ($fell(dq_oe_n));
endmodule
bind dbs_sram_port dbs_properties #(.LANES(LANES), .ADDR_W(ADDR_W)) u_props (
   .clk, .rst_b, .clk_pins, .single_clock_mode, .cycle_define_n, .read_not_write,
   .addr_hi, .burst_start_bit, .byte_lane_en_n, .dq_in, .dq_out, .dq_oe_n, .echo_timing_pair
);

// >>> dbs_sram_port.sv
`timescale 1ns/100ps
module dbs_sram_port
   import dbs_pkg::*;
#(
   parameter int LANES  = DBS_LANES,
   parameter int ADDR_W = DBS_ADDR_W
)
(
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire dbs_clk_pins_t               clk_pins,
   input  wire logic                        single_clock_mode,
   input  wire logic                        cycle_define_n,
   input  wire logic                        read_not_write,
   input  wire logic [ADDR_W-2:0]           addr_hi,
   input  wire logic                        burst_start_bit,
   input  wire logic [LANES-1:0]            byte_lane_en_n,
   input  wire logic [LANES*DBS_LANE_W-1:0] dq_in,
   output logic [LANES*DBS_LANE_W-1:0]      dq_out,
   output logic                             dq_oe_n,
   output logic [1:0]                       echo_timing_pair
);

   localparam int DW    = LANES * DBS_LANE_W;
   localparam int DEPTH = 2 ** (ADDR_W - 1);

   typedef struct packed {
      dbs_phase_t         phase;
      logic [ADDR_W-2:0]  row;
      logic               bcnt;
      logic [1:0]         words;
      dbs_clk_pins_t      pins_prev;
      logic [DW-1:0]      dq_out;
      logic               dq_oe_n;
      logic [1:0]         echo;
   } dbs_port_state_t;

   dbs_port_state_t st_r;
   dbs_port_state_t st_nxt;

   // each bank holds one half of the word space, picked by the burst bit
   logic [DW-1:0] bank_mem [DBS_BANKS][DEPTH];

   logic          k_rise;
   logic          kn_rise;
   logic          c_rise;
   logic          cn_rise;
   logic          launch;
   logic          cmd_take;
   logic          wr_en;
   logic [DW-1:0] wr_mask;
   logic [DW-1:0] rd_word;
   logic          fifo_in_valid;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic          fifo_out_ready;
   logic [DW-1:0] fifo_out_data;

   // =========================================================
   // clock edge detection
   // =========================================================
   assign k_rise  = clk_pins.in_k    & ~st_r.pins_prev.in_k;
   assign kn_rise = clk_pins.in_k_n  & ~st_r.pins_prev.in_k_n;
   assign c_rise  = clk_pins.out_c   & ~st_r.pins_prev.out_c;
   assign cn_rise = clk_pins.out_c_n & ~st_r.pins_prev.out_c_n;

   // read data leaves on the output pair unless the device runs from one pair
   assign launch = single_clock_mode ? (k_rise | kn_rise) : (c_rise | cn_rise);

   // =========================================================
   // lane masks
   // =========================================================
   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++)
      begin : g_lane
         // lanes are sampled on the very edge that carries the word
         assign wr_mask[gl*DBS_LANE_W +: DBS_LANE_W] =
            {DBS_LANE_W{~byte_lane_en_n[gl]}};
      end
   endgenerate

   assign rd_word = bank_mem[st_r.bcnt][st_r.row];

   // =========================================================
   // burst sequencing
   // =========================================================
   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.pins_prev = clk_pins;
      cmd_take         = 1'b0;
      wr_en            = 1'b0;
      fifo_in_valid    = 1'b0;

      case (st_r.phase)
         DBS_IDLE:
         begin
            cmd_take = k_rise;
         end
         DBS_WR_LO:
         begin
            if (kn_rise)
            begin
               wr_en = 1'b1;
            end
         end
         DBS_WR_HI:
         begin
            if (k_rise)
            begin
               wr_en    = 1'b1;
               // the closing edge of a write may also open the next burst
               cmd_take = 1'b1;
            end
         end
         DBS_RD_LO,
         DBS_RD_HI:
         begin
            // a full read buffer holds the sequencer here
            fifo_in_valid = 1'b1;
         end
         default:
         begin
            st_nxt.phase = DBS_IDLE;
         end
      endcase

      if (wr_en || (fifo_in_valid && fifo_in_ready))
      begin
         st_nxt.bcnt  = ~st_r.bcnt;
         st_nxt.words = st_r.words + 1'b1;
         if (st_r.words == 2'(DBS_BURST_LEN - 1))
         begin
            st_nxt.phase = DBS_IDLE;
         end
         else
         begin
            st_nxt.phase = (st_r.phase == DBS_WR_LO) ? DBS_WR_HI : DBS_RD_HI;
         end
      end

      if (cmd_take && !cycle_define_n)
      begin
         // one address bus, the direction bit names its use
         st_nxt.row   = addr_hi;
         st_nxt.bcnt  = burst_start_bit;
         st_nxt.words = '0;
         st_nxt.phase = read_not_write ? DBS_RD_LO : DBS_WR_LO;
      end

      // =====================================================
      // output launch
      // =====================================================
      fifo_out_ready = launch;
      if (launch)
      begin
         if (fifo_out_valid)
         begin
            st_nxt.dq_out  = fifo_out_data;
            st_nxt.dq_oe_n = 1'b0;
         end
         else
         begin
            st_nxt.dq_oe_n = 1'b1;
         end
      end

      // echo pair runs whether or not data moves
      st_nxt.echo = single_clock_mode ? {clk_pins.in_k_n, clk_pins.in_k}
                                      : {clk_pins.out_c_n, clk_pins.out_c};
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r         <= '0;
         st_r.phase   <= DBS_IDLE;
         st_r.bcnt    <= DBS_BCNT_RST;
         st_r.dq_oe_n <= DBS_OE_N_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // storage
   // =========================================================
   // the array is not reset: contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         bank_mem[st_r.bcnt][st_r.row] <= (dq_in & wr_mask)
                                        | (rd_word & ~wr_mask);
      end
   end

   // =========================================================
   // read buffer
   // =========================================================
   dbs_fifo #(
      .W     (DW),
      .DEPTH (DBS_FIFO_DEPTH)
   ) u_rd_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (rd_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   assign dq_out           = st_r.dq_out;
   assign dq_oe_n          = st_r.dq_oe_n;
   assign echo_timing_pair = st_r.echo;

endmodule

// >>> test_ddr_burst2_sram_port.sv
`timescale 1ns/100ps
module test_ddr_burst2_sram_port;
   import dbs_pkg::*;
   localparam int AW = 6;
   localparam int W  = DBS_LANE_W * DBS_LANES;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          single_clock_mode = 1'b0;
   logic          cycle_define_n = 1'b1;
   logic          read_not_write = 1'b0;
   logic          burst_start_bit = 1'b0;
   logic [AW-2:0] addr_hi = 5'h00;
   logic [3:0]    byte_lane_en_n = 4'hf;
   logic [W-1:0]  dq_in = 36'h0;
   logic [W-1:0]  dq_out;
   logic          dq_oe_n;
   logic [1:0]    echo_timing_pair;
   dbs_clk_pins_t clk_pins;
   logic [W-1:0]  mem [0:2**AW-1];
   int            n_mismatch = 0;
   int            checks = 0;
   always #12.5 clk = ~clk;
   dbs_ctrl_model u_ctrl (.clk, .clk_pins);
   dbs_sram_port #(.LANES(DBS_LANES), .ADDR_W(AW)) DUT (.clk, .rst_b, .clk_pins,
      .single_clock_mode, .cycle_define_n, .read_not_write, .addr_hi, .burst_start_bit,
      .byte_lane_en_n, .dq_in, .dq_out, .dq_oe_n, .echo_timing_pair);
   // ====
   // shared tasks
   // ====
   task automatic finish_test;
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp_d(input logic [W-1:0] got, input logic [W-1:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %0t data %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_f(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %0t flag %b exp %b", $time, got, exp);
      end
   endtask
   function automatic void upd(input logic [AW-1:0] x, input logic [W-1:0] d,
                               input logic [3:0] e);
      for (int i = 0; i < 4; i++)
         if (!e[i])
            mem[x][9*i+:9] = d[9*i+:9];
   endfunction
   task automatic wr(input logic [AW-2:0] a, input logic b, input logic [W-1:0] d0,
                     input logic [W-1:0] d1, input logic [3:0] e0, input logic [3:0] e1);
      @(posedge clk_pins.in_k_n);
      cycle_define_n = 1'b0;
      addr_hi = a;
      burst_start_bit = b;
      @(posedge clk_pins.in_k_n);
      cycle_define_n = 1'b1;
      addr_hi = ~a;
      dq_in = d0;
      byte_lane_en_n = e0;
      @(posedge clk_pins.in_k);
      dq_in = d1;
      byte_lane_en_n = e1;
      upd({a, b}, d0, e0);
      upd({a, ~b}, d1, e1);
   endtask
   // a word window lasts four clk, so each word is sampled once inside it
   task automatic rd(input logic [AW-2:0] a, input logic b);
      int n;
      n = 0;
      @(posedge clk_pins.in_k_n);
      cycle_define_n = 1'b0;
      read_not_write = 1'b1;
      addr_hi = a;
      burst_start_bit = b;
      @(posedge clk_pins.in_k);
      @(negedge clk);
      cycle_define_n = 1'b1;
      read_not_write = 1'b0;
      while (dq_oe_n !== 1'b0 && n < 16)
      begin
         @(negedge clk);
         n++;
      end
      cmp_d(dq_out, mem[{a, b}]);
      repeat (4) @(negedge clk);
      cmp_d(dq_out, mem[{a, ~b}]);
      repeat (4) @(negedge clk);
      cmp_f(dq_oe_n, 1'b1);
   endtask
   // ====
   // scenarios
   // ====
   task automatic t_idle;
      read_not_write = 1'b1;
      repeat (16)
      begin
         @(negedge clk);
         addr_hi = addr_hi + 5'h01;
         cmp_f(dq_oe_n, 1'b1);
         // pins move only on the falling edge, so the echo must match them here
         @(posedge clk);
         #1;
         cmp_f(echo_timing_pair[0], clk_pins.out_c);
         cmp_f(echo_timing_pair[1], clk_pins.out_c_n);
      end
      read_not_write = 1'b0;
   endtask
   task automatic t_reset;
      @(negedge clk);
      rst_b = 1'b0;
      @(negedge clk);
      cmp_f(dq_oe_n, 1'b1);
      cmp_f(echo_timing_pair[0], 1'b0);
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_basic;
      wr(5'h05, 1'b0, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
      rd(5'h05, 1'b0);
   endtask
   task automatic t_lanes;
      wr(5'h05, 1'b0, 36'hfffffffff, 36'h000000000, 4'ha, 4'h5);
      rd(5'h05, 1'b0);
   endtask
   task automatic t_wrap;
      wr(5'h0a, 1'b1, 36'h0f0f0f0f0, 36'h5a5a5a5a5, 4'h0, 4'h0);
      rd(5'h0a, 1'b1);
      rd(5'h0a, 1'b0);
   endtask
   task automatic t_single;
      single_clock_mode = 1'b1;
      @(posedge clk);
      #1;
      cmp_f(echo_timing_pair[0], clk_pins.in_k);
      rd(5'h0a, 1'b1);
      single_clock_mode = 1'b0;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
   initial
   begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      t_idle;
      t_basic;
      t_lanes;
      t_wrap;
      t_reset;
      t_single;
      finish_test;
   end
endmodule
